// ===== adcs_pkg.sv
/*
 * Package for the converter timing sequencer: control field layout, phase
 * length record type in half-CPU-clock units, reset values and shared types.
 * Assumes a single CPU clock domain feeding the sequencer.
 */
package adcs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Converter control register layout (16-bit view: timing fields in the top bits, power-off at bit 6)
    localparam int CTRL_WIDTH = 16;
    localparam int CONV_TIME_LSB = 14;
    localparam int SAMPLE_TIME_LSB = 12;
    localparam int POWER_OFF_BIT = 6;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Result width and end-of-scale codes
    localparam int RESULT_WIDTH = 10;
    localparam logic [9:0] RESULT_ZERO = 10'h000;
    localparam logic [9:0] RESULT_FULL = 10'h3FF;
    localparam logic [9:0] RESULT_RESET = 10'h000;

    ////////////////////////////////////////////////////////////////////////
    // Phase counting: one CPU clock equals two half-CPU-clock units
    localparam int UNITS_PER_CLK = 2;
    localparam int CNT_WIDTH = 11;
    localparam logic [3:0] SAR_LAST_BIT = 4'h9;

    typedef logic [CNT_WIDTH-1:0] adcs_cnt_t;

    typedef enum logic [1:0] {
        ADCS_IDLE = 2'b00,
        ADCS_SAMPLE = 2'b01,
        ADCS_COMPARE = 2'b10,
        ADCS_EXTRA = 2'b11
    } adcs_state_t;

    // Phase lengths for one timing setting, in half-CPU-clock units
    typedef struct packed {
        adcs_cnt_t sample_units;
        adcs_cnt_t compare_units;
        adcs_cnt_t extra_units;
    } adcs_timing_t;

    // Comparator interface toward the analog array
    typedef struct packed {
        logic sample_en;
        logic compare_en;
        logic [RESULT_WIDTH-1:0] trial_code;
    } adcs_analog_t;

endpackage : adcs_pkg

// ===== adcs_timing_rom.sv
/*
 * Maps the conversion-time and sample-time fields to the three phase lengths.
 * Purely combinational; the caller registers the result at conversion start.
 */
`timescale 1ns/100ps
module adcs_timing_rom
    import adcs_pkg::*;
(
    // Selection
    input wire logic [1:0] conversion_time_field,
    input wire logic [1:0] sample_time_field,
    // Phase lengths
    output adcs_timing_t timing
);

    function automatic adcs_timing_t mk(input int s, input int c, input int e);
        adcs_timing_t t;
        t.sample_units = CNT_WIDTH'(s);
        t.compare_units = CNT_WIDTH'(c);
        t.extra_units = CNT_WIDTH'(e);
        return t;
    endfunction : mk

    always_comb begin
        case ({conversion_time_field, sample_time_field})
            4'h0: timing = mk(120, 240, 28);
            4'h1: timing = mk(140, 280, 16);
            4'h2: timing = mk(200, 280, 52);
            4'h3: timing = mk(400, 280, 44);
            4'hC: timing = mk(240, 480, 52);
            4'hD: timing = mk(280, 560, 28);
            4'hE: timing = mk(400, 560, 100);
            4'hF: timing = mk(800, 560, 52);
            4'h8: timing = mk(480, 960, 100);
            4'h9: timing = mk(560, 1120, 52);
            4'hA: timing = mk(800, 1120, 196);
            4'hB: timing = mk(1600, 1120, 164);
            // Reserved code 01 falls back to the slowest setting
            default: timing = mk(1600, 1120, 164);
        endcase
    end

endmodule : adcs_timing_rom

// ===== adcs_sar.sv
/*
 * Successive-approximation register: walks 10 trial bits MSB first, keeping
 * each bit the comparator accepts. Assumes step pulses from the sequencer.
 */
`timescale 1ns/100ps
module adcs_sar
    import adcs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic step,
    input wire logic cmp_keep,
    // Trial code
    output logic [RESULT_WIDTH-1:0] code,
    output logic [RESULT_WIDTH-1:0] trial
);

    logic [RESULT_WIDTH-1:0] mask;
    logic [RESULT_WIDTH-1:0] next_code;
    logic [RESULT_WIDTH-1:0] next_mask;

    assign trial = code | mask;

    always_comb begin
        next_code = code;
        next_mask = mask;
        if (start) begin
            next_code = RESULT_ZERO;
            next_mask = RESULT_WIDTH'(1) << (RESULT_WIDTH - 1);
        end else if (step && mask != RESULT_ZERO) begin
            // Keeping every bit gives all-ones above reference, none below ground
            if (cmp_keep) begin
                next_code = code | mask;
            end
            next_mask = mask >> 1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code <= RESULT_ZERO;
            mask <= RESULT_ZERO;
        end else begin
            code <= next_code;
            mask <= next_mask;
        end
    end

endmodule : adcs_sar

// ===== adcs_sequencer.sv
/*
 * Conversion timing sequencer for a 10-bit successive-approximation converter.
 * Runs sample, comparison and result-transfer phases whose lengths come from
 * the top four bits of the converter control register.
 * Assumes clk is the CPU clock; start and control come from CPU-clock logic,
 * the comparator answer comes from the analog array and is synchronised.
 */
`timescale 1ns/100ps
module adcs_sequencer
    import adcs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control from the CPU side
    input wire logic [CTRL_WIDTH-1:0] converter_control_register,
    input wire logic start,
    // Comparator answer from the analog array
    input wire logic cmp_above,
    // Analog array controls
    output adcs_analog_t analog,
    output logic analog_power_en,
    // Result and status
    output logic [RESULT_WIDTH-1:0] result,
    output logic busy,
    output logic done
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release and input synchroniser
    logic [1:0] rst_sync;
    logic [1:0] next_rst_sync;
    logic rst_n;
    logic cmp_meta;
    logic cmp_sync;
    logic next_cmp_meta;
    logic next_cmp_sync;

    // Release goes through two flops so every flop reset by rst_n leaves reset on one clean edge
    always_comb begin
        next_rst_sync = {rst_sync[0], 1'b1};
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= next_rst_sync;
        end
    end
    assign rst_n = rst_sync[1];

    // The comparator settles on its own timing; only the second flop is read
    always_comb begin
        next_cmp_meta = cmp_above;
        next_cmp_sync = cmp_meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            cmp_meta <= next_cmp_meta;
            cmp_sync <= next_cmp_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timing selection
    logic [1:0] conversion_time_field;
    logic [1:0] sample_time_field;
    logic converter_power_off_bit;
    adcs_timing_t table_timing;

    assign conversion_time_field = converter_control_register[CONV_TIME_LSB +: 2];
    assign sample_time_field = converter_control_register[SAMPLE_TIME_LSB +: 2];
    assign converter_power_off_bit = converter_control_register[POWER_OFF_BIT];

    adcs_timing_rom u_rom (
        .conversion_time_field(conversion_time_field),
        .sample_time_field(sample_time_field),
        .timing(table_timing)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    adcs_state_t state;
    adcs_state_t next_state;
    adcs_timing_t timing;
    adcs_timing_t next_timing;
    adcs_cnt_t units;
    adcs_cnt_t next_units;
    adcs_cnt_t step_units;
    adcs_cnt_t next_step_units;
    logic [RESULT_WIDTH-1:0] next_result;
    logic next_done;
    logic sar_start;
    logic sar_step;
    logic [RESULT_WIDTH-1:0] sar_code;
    logic [RESULT_WIDTH-1:0] sar_trial;

    // Units elapsed after the current clock, two per CPU clock
    function automatic adcs_cnt_t tick(input adcs_cnt_t u);
        return u + CNT_WIDTH'(UNITS_PER_CLK);
    endfunction : tick

    // Comparison time is shared evenly among the ten bit decisions
    function automatic adcs_cnt_t per_bit(input adcs_cnt_t total);
        return CNT_WIDTH'(total / RESULT_WIDTH);
    endfunction : per_bit

    // True when the units counted after this clock reach the phase length
    function automatic logic reached(input adcs_cnt_t u, input adcs_cnt_t len);
        return tick(u) >= len;
    endfunction : reached

    ////////////////////////////////////////////////////////////////////////
    // Phase end decode
    logic sample_end;
    logic compare_end;
    logic extra_end;
    logic step_end;
    logic finish;

    always_comb begin
        sample_end = reached(units, timing.sample_units);
        compare_end = reached(units, timing.compare_units);
        extra_end = reached(units, timing.extra_units);
        step_end = reached(step_units, per_bit(timing.compare_units));
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit decision count
    logic [3:0] bit_idx;
    logic [3:0] next_bit_idx;
    logic bits_left;

    // Caps the walk at ten decisions even if a step length were ever uneven
    assign bits_left = (bit_idx <= SAR_LAST_BIT);

    always_comb begin
        next_bit_idx = bit_idx;
        if (sar_start) begin
            next_bit_idx = 4'h0;
        end else if (sar_step) begin
            next_bit_idx = bit_idx + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_idx <= 4'h0;
        end else begin
            bit_idx <= next_bit_idx;
        end
    end

    always_comb begin
        next_state = state;
        next_timing = timing;
        next_units = units;
        next_step_units = step_units;
        finish = 1'b0;
        sar_start = 1'b0;
        sar_step = 1'b0;
        case (state)
            ADCS_IDLE: begin
                // A powered-off converter ignores start requests
                if (start && !converter_power_off_bit) begin
                    next_timing = table_timing;
                    next_units = '0;
                    next_state = ADCS_SAMPLE;
                end
            end
            ADCS_SAMPLE: begin
                next_units = tick(units);
                if (sample_end) begin
                    next_units = '0;
                    next_step_units = '0;
                    sar_start = 1'b1;
                    next_state = ADCS_COMPARE;
                end
            end
            ADCS_COMPARE: begin
                next_units = tick(units);
                next_step_units = tick(step_units);
                if (step_end) begin
                    next_step_units = '0;
                    sar_step = bits_left;
                end
                if (compare_end) begin
                    next_units = '0;
                    next_state = ADCS_EXTRA;
                end
            end
            ADCS_EXTRA: begin
                next_units = tick(units);
                if (extra_end) begin
                    next_units = '0;
                    finish = 1'b1;
                    next_state = ADCS_IDLE;
                end
            end
            default: begin
                next_state = ADCS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ADCS_IDLE;
            timing <= '0;
            units <= '0;
            step_units <= '0;
        end else begin
            state <= next_state;
            timing <= next_timing;
            units <= next_units;
            step_units <= next_step_units;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result word and completion pulse
    // Both change on one edge, so done never comes with the old word
    always_comb begin
        next_result = result;
        next_done = 1'b0;
        if (finish) begin
            next_result = sar_code;
            next_done = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= RESULT_RESET;
            done <= 1'b0;
        end else begin
            result <= next_result;
            done <= next_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit resolution
    adcs_sar u_sar (
        .clk(clk),
        .rst_n(rst_n),
        .start(sar_start),
        .step(sar_step),
        .cmp_keep(cmp_sync),
        .code(sar_code),
        .trial(sar_trial)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs to the analog array
    adcs_analog_t next_analog;
    logic next_busy;
    logic next_power_en;

    always_comb begin
        next_analog.sample_en = (next_state == ADCS_SAMPLE);
        next_analog.compare_en = (next_state == ADCS_COMPARE);
        next_analog.trial_code = sar_trial;
        next_busy = (next_state != ADCS_IDLE);
        next_power_en = !converter_power_off_bit;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            analog <= '0;
            analog_power_en <= 1'b0;
            busy <= 1'b0;
        end else begin
            analog <= next_analog;
            analog_power_en <= next_power_en;
            busy <= next_busy;
        end
    end

endmodule : adcs_sequencer

// ===== adcs_tb_pkg.sv
/* Bench-side phase table in half-clock units, indexed {conv field, sample field}.
   Assumes the control field layout of adcs_pkg. */
package adcs_tb_pkg;
    // Reserved conversion field 01 runs the slowest setting
    localparam int SMP[16] = '{120, 140, 200, 400, 1600, 1600, 1600, 1600,
        480, 560, 800, 1600, 240, 280, 400, 800};
    localparam int CMP[16] = '{240, 280, 280, 280, 1120, 1120, 1120, 1120,
        960, 1120, 1120, 1120, 480, 560, 560, 560};
    localparam int EXT[16] = '{28, 16, 52, 44, 164, 164, 164, 164,
        100, 52, 196, 164, 52, 28, 100, 52};
endpackage : adcs_tb_pkg

// ===== adcs_sequencer_sva.sv
/* Checker for adcs_sequencer: phase lengths, done pulse, power-off gating.
   Assumes starts come at least three edges after reset release. */
`timescale 1ns/100ps
module adcs_sequencer_sva
    import adcs_pkg::*, adcs_tb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Requests
    input wire logic [CTRL_WIDTH-1:0] converter_control_register,
    input wire logic start,
    // Answers
    input wire adcs_analog_t analog,
    input wire logic analog_power_en,
    input wire logic [RESULT_WIDTH-1:0] result,
    input wire logic busy,
    input wire logic done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic [1:0] rel;
    logic [10:0] cnt;
    logic [3:0] sel;
    logic off;
    logic taken;
    int s2, c2, e2;
    assign off = converter_control_register[POWER_OFF_BIT];
    // Starts before the internal reset copy settles are not counted
    assign taken = start && !busy && !done && !off && rel == 2'h3;
    assign s2 = SMP[sel] / 2;
    assign c2 = CMP[sel] / 2;
    assign e2 = EXT[sel] / 2;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rel <= 2'h0;
            cnt <= 11'h000;
            sel <= 4'h0;
        end else begin
            if (rel != 2'h3) begin
                rel <= rel + 2'h1;
            end
            if (taken) begin
                cnt <= 11'h001;
                sel <= converter_control_register[15:12];
            end else if (busy) begin
                cnt <= cnt + 11'h001;
            end
        end
    end

    ////////////////////////////////////////
    sequence s_taken;
        taken;
    endsequence
    sequence s_sampling;
        busy && analog.sample_en && !analog.compare_en;
    endsequence
    sequence s_comparing;
        busy && analog.compare_en && !analog.sample_en;
    endsequence

    AST_SAMPLE_FIRST: assert property (s_taken |=> s_sampling)
        else $error("no sample phase after start");
    AST_SAMPLE_LEN: assert property ($fell(analog.sample_en) |-> s_comparing ##0 cnt == s2 + 1)
        else $error("sample phase length wrong");
    AST_COMPARE_LEN: assert property ($fell(analog.compare_en) |-> busy && cnt == s2 + c2 + 1)
        else $error("compare phase length wrong");
    AST_TOTAL: assert property (done |-> cnt == s2 + c2 + e2 + 1)
        else $error("conversion length wrong");
    AST_DONE_PULSE: assert property (done |=> !done)
        else $error("done longer than one cycle");
    AST_BUSY_DROP: assert property ($fell(busy) |-> done)
        else $error("busy fell without done");
    AST_NO_RESTART: assert property (s_comparing ##0 start |=> !analog.sample_en)
        else $error("start taken while busy");
    AST_OFF_REFUSED: assert property (start && off && !busy && !done |=> !busy)
        else $error("start taken while powered off");
    AST_POWER_OFF: assert property (off ##1 off |-> !analog_power_en)
        else $error("analog power on while off");
    AST_POWER_ON: assert property (rel == 2'h3 && !off ##1 !off |-> analog_power_en)
        else $error("analog power off while on");
    AST_RESULT_HOLD: assert property (!done |-> $stable(result))
        else $error("result changed without done");
endmodule : adcs_sequencer_sva

bind adcs_sequencer adcs_sequencer_sva chk (.clk, .nrst, .converter_control_register,
    .start, .analog, .analog_power_en, .result, .busy, .done);

// ===== adcs_sequencer_bench.sv
/* Self-checking bench for adcs_sequencer; stands in for the comparator.
   Assumes adcs_sequencer_sva is bound to the design. */
`timescale 1ns/100ps
module adcs_sequencer_bench
    import adcs_pkg::*, adcs_tb_pkg::*;
();
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [CTRL_WIDTH-1:0] ctrl = CTRL_RESET;
    logic start = 1'b0;
    logic cmp_above = 1'b0;
    logic [RESULT_WIDTH-1:0] vin = 10'h000;
    adcs_analog_t analog;
    logic power_en;
    logic [RESULT_WIDTH-1:0] result;
    logic busy;
    logic done;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;

    adcs_sequencer uut (
        .clk(clk),
        .nrst(nrst),
        .converter_control_register(ctrl),
        .start(start),
        .cmp_above(cmp_above),
        .analog(analog),
        .analog_power_en(power_en),
        .result(result),
        .busy(busy),
        .done(done)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    // Ideal comparator, so a correct walk must return vin exactly
    always @(posedge clk) begin
        cmp_above <= vin >= analog.trial_code;
    end

    // Whole run needs about 14300 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            $display("[FAIL] %0t timeout", $time);
            tally_and_finish();
        end
    end

    ////////////////////////////////////////
    task automatic chk_int(input int got, input int exp, input string what);
        num_checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: %0d, want %0d", $time, what, got, exp);
        end
    endtask : chk_int

    task automatic chk_vec(input logic [9:0] got, input logic [9:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: %h, want %h", $time, what, got, exp);
        end
    endtask : chk_vec

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // Mid 1 pokes start in the compare phase, mid 2 sets power-off there
    task automatic run_conv(input logic [3:0] sel, input logic [9:0] v, input int mid);
        int n, ns, nc, k;
        n = 0;
        ns = 0;
        nc = 0;
        k = SMP[sel] / 2 + 4;
        @(posedge clk);
        ctrl <= {sel, 12'h000};
        vin <= v;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        // Sample enable already rises on the taking edge itself
        #1;
        if (analog.sample_en === 1'b1) ns++;
        do begin
            @(posedge clk);
            start <= (mid == 1 && n == k);
            if (mid == 2 && n == k) begin
                ctrl[POWER_OFF_BIT] <= 1'b1;
            end
            #1;
            n++;
            if (analog.sample_en === 1'b1) ns++;
            if (analog.compare_en === 1'b1) nc++;
        end while (done !== 1'b1 && n < 3000);
        chk_int(n, (SMP[sel] + CMP[sel] + EXT[sel]) / 2, "total cycles");
        chk_int(ns, SMP[sel] / 2, "sample cycles");
        chk_int(nc, CMP[sel] / 2, "compare cycles");
        chk_vec(result, v, "result");
        chk_vec({9'h000, busy}, 10'h000, "busy at done");
    endtask : run_conv

    task automatic t_reset_state();
        chk_vec({9'h000, busy}, 10'h000, "busy after reset");
        chk_vec(result, RESULT_RESET, "result after reset");
        chk_vec({9'h000, power_en}, 10'h001, "power after reset");
    endtask : t_reset_state

    task automatic t_all_timings();
        for (int i = 0; i < 16; i++) begin
            run_conv(4'(i), 10'h155 + 10'(i * 37), 0);
        end
    endtask : t_all_timings

    task automatic t_scale_ends();
        run_conv(4'h0, RESULT_FULL, 0);
        run_conv(4'h0, RESULT_ZERO, 0);
    endtask : t_scale_ends

    task automatic t_busy_restart();
        run_conv(4'hD, 10'h0F0, 1);
    endtask : t_busy_restart

    // Power-off mid-run must not abort, but must refuse the next start
    task automatic t_power_off();
        run_conv(4'h1, 10'h2A5, 2);
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk_vec({9'h000, power_en}, 10'h000, "power when off");
        chk_vec({9'h000, busy}, 10'h000, "start when off");
        run_conv(4'h0, 10'h001, 0);
    endtask : t_power_off

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        t_reset_state();
        t_all_timings();
        t_scale_ends();
        t_busy_restart();
        t_power_off();
        tally_and_finish();
    end
endmodule : adcs_sequencer_bench
